// ==== common/rhc_pkg.sv ====
// package: constants and types of the runtime hours counters
// ============================================================
// Behaviour
// - total runtime millisecond field counts and clears to zero after one day
// - total runtime day field advances each time the millisecond field wraps
// - total runtime is written to nonvolatile storage on power-down
// - after power-up total runtime reloads from storage and counting resumes
// - relative runtime counts milliseconds since reset, wrapping after 49 days
// - motor hours advance while the pulse enable is active
// - pulse enable withdrawn halts motor hours and stores them persistently
// - maintenance interval of zero disables motor hours counting
// - motor hours reaching maintenance interval raises the maintenance fault
// - fan hours accept only written zero; other values are rejected
// - fan alarm rises once fan hours are within 500 of service life
// - fan service life of zero suppresses the fan alarm
package rhc_pkg;
    // ============================================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_PER_DAY = 86400000;
    localparam int MS_PER_HOUR = 3600000;
    localparam int FAN_WARN_HOURS = 500;
    // ============================================================
    // nonvolatile word map
    localparam int NV_WORDS = 4;
    localparam logic [1:0] NV_TOTAL_MS = 2'h0;
    localparam logic [1:0] NV_TOTAL_DAYS = 2'h1;
    localparam logic [1:0] NV_MOTOR_HOURS = 2'h2;
    localparam logic [1:0] NV_FAN_HOURS = 2'h3;
    // ============================================================
    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_TOTAL_MS = 8'h00;
    localparam logic [7:0] OFS_TOTAL_DAYS = 8'h04;
    localparam logic [7:0] OFS_REL_MS = 8'h08;
    localparam logic [7:0] OFS_MOTOR_HOURS = 8'h0c;
    localparam logic [7:0] OFS_MAINT_INTERVAL = 8'h10;
    localparam logic [7:0] OFS_FAN_HOURS = 8'h14;
    localparam logic [7:0] OFS_FAN_LIFE = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [31:0] MAINT_RESET = 32'h0000_0000;
    localparam logic [31:0] FAN_LIFE_RESET = 32'h0000_0000;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;
    // ============================================================
    // interrupt and status bit positions
    localparam int IRQ_W = 4;
    localparam int IRQ_MAINT = 0;
    localparam int IRQ_FAN = 1;
    localparam int IRQ_FAN_REJ = 2;
    localparam int IRQ_SAVED = 3;
    localparam int STS_RUNNING = 0;
    localparam int STS_MAINT = 1;
    localparam int STS_FAN = 2;
    localparam int STS_PULSE = 3;
    localparam int STS_FAN_RUN = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ============================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_LOAD = 3'h1,
        ST_RUN = 3'h2,
        ST_SAVE = 3'h4
    } rhc_state_t;
endpackage

// ==== rtl/rhc_cnt.sv ====
// wrapping counter with load, shared by all counters of the block
`timescale 1ns/100ps
`default_nettype none
module rhc_cnt #(
    parameter int W = 32,
    parameter logic [W-1:0] MAXV = '1
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic inc_in,
    input wire logic ld_in,
    input wire logic [W-1:0] val_in,
    output logic [W-1:0] cnt_out,
    output logic wrap_out
);
    // ============================================================
    // count
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cnt_out <= '0;
        end else if (ld_in) begin
            cnt_out <= val_in;
        end else if (inc_in) begin
            cnt_out <= (cnt_out == MAXV) ? '0 : cnt_out + 1'b1;
        end
    end

    // load has priority, so a wrap is lost only when software overwrites
    assign wrap_out = inc_in && !ld_in && (cnt_out == MAXV);
endmodule
`default_nettype wire

// ==== rtl/rhc_nvmem.sv ====
// retained storage for counter snapshots, survives the block reset
`timescale 1ns/100ps
`default_nettype none
module rhc_nvmem #(
    parameter int DEPTH = 4,
    parameter int W = 32
) (
    input wire logic clk_in,
    input wire logic clr_in,
    input wire logic we_in,
    input wire logic [$clog2(DEPTH)-1:0] waddr_in,
    input wire logic [W-1:0] wdata_in,
    input wire logic [$clog2(DEPTH)-1:0] raddr_in,
    output logic [W-1:0] rdata_out
);
    logic [W-1:0] mem_q [DEPTH];

    if (DEPTH < 2) begin : g_bad_depth
        $error("rhc_nvmem needs at least two words");
    end

    // ============================================================
    // storage: no reset on purpose, only a cold clear wipes it
    always_ff @(posedge clk_in) begin
        if (clr_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (we_in) begin
            mem_q[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rdata_out <= mem_q[raddr_in];
    end
endmodule
`default_nettype wire

// ==== rtl/rhc_top.sv ====
// runtime and operating hours counters with an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module rhc_top import rhc_pkg::*; #(
    parameter int CYC_MS = CYC_PER_MS,
    parameter int MS_HOUR = MS_PER_HOUR
) (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic PULSE_EN_IN,
    input wire logic FAN_RUN_IN,
    input wire logic PWR_FAIL_IN,
    input wire logic NV_CLEAR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [ADDR_W-1:0] AWADDR_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    output logic [1:0] BRESP_OUT,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    input wire logic [ADDR_W-1:0] ARADDR_IN,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic IRQ_OUT,
    output logic MAINT_FAULT_OUT,
    output logic FAN_ALARM_OUT
);
    localparam int PW = $clog2(CYC_MS);
    localparam int HW = $clog2(MS_HOUR);

    if (CYC_MS < 2 || MS_HOUR < 2) begin : g_bad_param
        $error("rhc_top: prescaler counts must be at least two");
    end

    rhc_state_t st_q;
    logic [1:0] idx_q, ld_idx_q;
    logic ld_pend_q, save_req_q, pf_q, pe_q;
    logic cnt_en, ms_tick, day_wrap, motor_run, motor_hr, fan_hr;
    logic [PW-1:0] presc;
    logic [HW-1:0] motor_sub, fan_sub;
    logic [31:0] total_ms, total_days, rel_ms, motor_hours, fan_hours;
    logic [31:0] maint_q, fan_life_q, nv_rdata, nv_wdata;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, wr_merged, rd_d;
    logic [3:0] wstrb_q;
    logic [1:0] rresp_d, bresp_d;
    logic [IRQ_W-1:0] irq_sts_q, irq_en_q, irq_set;
    logic do_wr, fan_wr_ok, fan_wr_bad, maint_due, fan_due;
    logic ld_total, ld_days, ld_motor, ld_fan;

    // ============================================================
    // millisecond tick and runtime counters
    assign cnt_en = (st_q != ST_LOAD);

    rhc_cnt #(.W(PW), .MAXV(PW'(CYC_MS - 1))) u_presc (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .inc_in(1'b1),
        .ld_in(1'b0),
        .val_in('0),
        .cnt_out(presc),
        .wrap_out(ms_tick)
    );

    assign ld_total = ld_pend_q && (ld_idx_q == NV_TOTAL_MS);
    assign ld_days = ld_pend_q && (ld_idx_q == NV_TOTAL_DAYS);
    assign ld_motor = ld_pend_q && (ld_idx_q == NV_MOTOR_HOURS);
    assign ld_fan = ld_pend_q && (ld_idx_q == NV_FAN_HOURS);

    rhc_cnt #(.W(32), .MAXV(32'(MS_PER_DAY - 1))) u_total_ms (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .inc_in(ms_tick && cnt_en),
        .ld_in(ld_total),
        .val_in(nv_rdata),
        .cnt_out(total_ms),
        .wrap_out(day_wrap)
    );

    rhc_cnt #(.W(32)) u_total_days (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .inc_in(day_wrap),
        .ld_in(ld_days),
        .val_in(nv_rdata),
        .cnt_out(total_days),
        .wrap_out()
    );

    // full 32-bit span is 2^32 ms, about 49.7 days
    rhc_cnt #(.W(32)) u_rel_ms (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .inc_in(ms_tick),
        .ld_in(1'b0),
        .val_in('0),
        .cnt_out(rel_ms),
        .wrap_out()
    );

    // ============================================================
    // motor and fan operating hours
    assign motor_run = cnt_en && PULSE_EN_IN && (maint_q != '0);

    rhc_cnt #(.W(HW), .MAXV(HW'(MS_HOUR - 1))) u_motor_sub (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .inc_in(ms_tick && motor_run),
        .ld_in(1'b0),
        .val_in('0),
        .cnt_out(motor_sub),
        .wrap_out(motor_hr)
    );

    rhc_cnt #(.W(32)) u_motor_hours (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .inc_in(motor_hr),
        .ld_in(ld_motor),
        .val_in(nv_rdata),
        .cnt_out(motor_hours),
        .wrap_out()
    );

    rhc_cnt #(.W(HW), .MAXV(HW'(MS_HOUR - 1))) u_fan_sub (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .inc_in(ms_tick && cnt_en && FAN_RUN_IN),
        .ld_in(fan_wr_ok),
        .val_in('0),
        .cnt_out(fan_sub),
        .wrap_out(fan_hr)
    );

    rhc_cnt #(.W(32)) u_fan_hours (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .inc_in(fan_hr),
        .ld_in(ld_fan || fan_wr_ok),
        .val_in(ld_fan ? nv_rdata : 32'h0000_0000),
        .cnt_out(fan_hours),
        .wrap_out()
    );

    // levels recompute at once when software rewrites the interval
    assign maint_due = (maint_q != '0) && (motor_hours >= maint_q);
    assign fan_due = (fan_life_q != '0) &&
        ({1'b0, fan_hours} + 33'(FAN_WARN_HOURS) >= {1'b0, fan_life_q});

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            MAINT_FAULT_OUT <= 1'b0;
            FAN_ALARM_OUT <= 1'b0;
        end else begin
            MAINT_FAULT_OUT <= maint_due;
            FAN_ALARM_OUT <= fan_due;
        end
    end

    // ============================================================
    // restore and save sequencer
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            pf_q <= 1'b0;
            pe_q <= 1'b0;
            save_req_q <= 1'b0;
        end else begin
            pf_q <= PWR_FAIL_IN;
            pe_q <= PULSE_EN_IN;
            // a new request in the same cycle as the take-over wins
            if ((PWR_FAIL_IN && !pf_q) || (!PULSE_EN_IN && pe_q)) begin
                save_req_q <= 1'b1;
            end else if (st_q == ST_RUN) begin
                save_req_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            st_q <= ST_LOAD;
            idx_q <= 2'h0;
        end else begin
            unique case (st_q)
                ST_LOAD: begin
                    if (ld_pend_q && ld_idx_q == NV_FAN_HOURS) begin
                        st_q <= ST_RUN;
                        idx_q <= 2'h0;
                    end else if (idx_q != NV_FAN_HOURS) begin
                        idx_q <= idx_q + 2'h1;
                    end
                end
                ST_RUN: begin
                    if (save_req_q) begin
                        st_q <= ST_SAVE;
                        idx_q <= 2'h0;
                    end
                end
                ST_SAVE: begin
                    idx_q <= idx_q + 2'h1;
                    if (idx_q == NV_FAN_HOURS) begin
                        st_q <= ST_RUN;
                    end
                end
                default: begin
                    st_q <= ST_LOAD;
                    idx_q <= 2'h0;
                end
            endcase
        end
    end

    // read data lag the address by one cycle
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            ld_pend_q <= 1'b0;
            ld_idx_q <= 2'h0;
        end else begin
            ld_pend_q <= (st_q == ST_LOAD) &&
                !(ld_pend_q && ld_idx_q == NV_FAN_HOURS);
            ld_idx_q <= idx_q;
        end
    end

    always_comb begin
        unique case (idx_q)
            NV_TOTAL_MS: nv_wdata = total_ms;
            NV_TOTAL_DAYS: nv_wdata = total_days;
            NV_MOTOR_HOURS: nv_wdata = motor_hours;
            default: nv_wdata = fan_hours;
        endcase
    end

    rhc_nvmem #(.DEPTH(NV_WORDS), .W(32)) u_nvmem (
        .clk_in(CLK_IN),
        .clr_in(NV_CLEAR_IN),
        .we_in(st_q == ST_SAVE),
        .waddr_in(idx_q),
        .wdata_in(nv_wdata),
        .raddr_in(idx_q),
        .rdata_out(nv_rdata)
    );

    // ============================================================
    // AXI4-Lite write path
    assign do_wr = !AWREADY_OUT && !WREADY_OUT && !BVALID_OUT;
    always_comb begin
        wr_merged = maint_q;
        unique case (awaddr_q)
            OFS_FAN_HOURS: wr_merged = fan_hours;
            OFS_FAN_LIFE: wr_merged = fan_life_q;
            OFS_IRQ_CLEAR: wr_merged = 32'h0000_0000;
            OFS_IRQ_ENABLE: wr_merged = {28'h0, irq_en_q};
            default: wr_merged = maint_q;
        endcase
        for (int b = 0; b < 4; b++) begin
            if (wstrb_q[b]) begin
                wr_merged[8*b +: 8] = wdata_q[8*b +: 8];
            end
        end
    end
    assign fan_wr_ok = do_wr && awaddr_q == OFS_FAN_HOURS && wr_merged == '0;
    assign fan_wr_bad = do_wr && awaddr_q == OFS_FAN_HOURS && wr_merged != '0;

    always_comb begin
        unique case (awaddr_q)
            OFS_TOTAL_MS, OFS_TOTAL_DAYS, OFS_REL_MS, OFS_MOTOR_HOURS,
            OFS_MAINT_INTERVAL, OFS_FAN_HOURS, OFS_FAN_LIFE, OFS_IRQ_STATUS,
            OFS_IRQ_CLEAR, OFS_IRQ_ENABLE, OFS_STATUS: bresp_d = RESP_OKAY;
            default: bresp_d = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            AWREADY_OUT <= 1'b1;
            WREADY_OUT <= 1'b1;
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= 4'h0;
        end else begin
            if (AWVALID_IN && AWREADY_OUT) begin
                AWREADY_OUT <= 1'b0;
                awaddr_q <= {AWADDR_IN[ADDR_W-1:2], 2'h0};
            end
            if (WVALID_IN && WREADY_OUT) begin
                WREADY_OUT <= 1'b0;
                wdata_q <= WDATA_IN;
                wstrb_q <= WSTRB_IN;
            end
            if (do_wr) begin
                BVALID_OUT <= 1'b1;
                BRESP_OUT <= bresp_d;
            end else if (BVALID_OUT && BREADY_IN) begin
                BVALID_OUT <= 1'b0;
                AWREADY_OUT <= 1'b1;
                WREADY_OUT <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            maint_q <= MAINT_RESET;
            fan_life_q <= FAN_LIFE_RESET;
            irq_en_q <= IRQ_EN_RESET;
        end else if (do_wr) begin
            if (awaddr_q == OFS_MAINT_INTERVAL) begin
                maint_q <= wr_merged;
            end
            if (awaddr_q == OFS_FAN_LIFE) begin
                fan_life_q <= wr_merged;
            end
            if (awaddr_q == OFS_IRQ_ENABLE) begin
                irq_en_q <= wr_merged[IRQ_W-1:0];
            end
        end
    end

    // ============================================================
    // interrupts: sticky status, set wins over clear
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_MAINT] = maint_due && !MAINT_FAULT_OUT;
        irq_set[IRQ_FAN] = fan_due && !FAN_ALARM_OUT;
        irq_set[IRQ_FAN_REJ] = fan_wr_bad;
        irq_set[IRQ_SAVED] = (st_q == ST_SAVE) && (idx_q == NV_FAN_HOURS);
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            irq_sts_q <= '0;
            IRQ_OUT <= 1'b0;
        end else begin
            if (do_wr && awaddr_q == OFS_IRQ_CLEAR) begin
                irq_sts_q <= (irq_sts_q & ~wr_merged[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_sts_q <= irq_sts_q | irq_set;
            end
            IRQ_OUT <= |(irq_sts_q & irq_en_q);
        end
    end

    // ============================================================
    // AXI4-Lite read path, one cycle from address to data
    always_comb begin
        rd_d = 32'h0000_0000;
        rresp_d = RESP_OKAY;
        unique case ({ARADDR_IN[ADDR_W-1:2], 2'h0})
            OFS_TOTAL_MS: rd_d = total_ms;
            OFS_TOTAL_DAYS: rd_d = total_days;
            OFS_REL_MS: rd_d = rel_ms;
            OFS_MOTOR_HOURS: rd_d = motor_hours;
            OFS_MAINT_INTERVAL: rd_d = maint_q;
            OFS_FAN_HOURS: rd_d = fan_hours;
            OFS_FAN_LIFE: rd_d = fan_life_q;
            OFS_IRQ_STATUS: rd_d = {28'h0, irq_sts_q};
            OFS_IRQ_CLEAR: rd_d = 32'h0000_0000;
            OFS_IRQ_ENABLE: rd_d = {28'h0, irq_en_q};
            OFS_STATUS: begin
                rd_d[STS_RUNNING] = cnt_en;
                rd_d[STS_MAINT] = MAINT_FAULT_OUT;
                rd_d[STS_FAN] = FAN_ALARM_OUT;
                rd_d[STS_PULSE] = PULSE_EN_IN;
                rd_d[STS_FAN_RUN] = FAN_RUN_IN;
            end
            default: rresp_d = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            ARREADY_OUT <= 1'b1;
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= 32'h0000_0000;
            RRESP_OUT <= RESP_OKAY;
        end else if (ARVALID_IN && ARREADY_OUT) begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT <= 1'b1;
            RDATA_OUT <= rd_d;
            RRESP_OUT <= rresp_d;
        end else if (RVALID_OUT && RREADY_IN) begin
            ARREADY_OUT <= 1'b1;
            RVALID_OUT <= 1'b0;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    ms_wrap_a: assert property (
        ms_tick && cnt_en && total_ms == 32'(MS_PER_DAY - 1) && !ld_total
        |=> total_ms == 32'h0000_0000)
        else $error("day wrap of total ms missed");
    day_inc_a: assert property (
        day_wrap && !ld_days |=> total_days == $past(total_days) + 32'h1)
        else $error("day count did not advance");
    save_ms_a: assert property (
        PWR_FAIL_IN && !pf_q && st_q == ST_RUN && !save_req_q
        |-> ##2 (st_q == ST_SAVE && idx_q == NV_TOTAL_MS))
        else $error("power-down save not started");
    restore_a: assert property (
        ld_total |=> total_ms == $past(nv_rdata))
        else $error("total runtime not reloaded");
    rel_inc_a: assert property (
        ms_tick |=> rel_ms == $past(rel_ms) + 32'h1)
        else $error("relative runtime did not count");
    motor_hold_a: assert property (
        maint_q == '0 && !ld_motor |=> $stable(motor_hours))
        else $error("motor hours moved while disabled");
    motor_save_a: assert property (
        !PULSE_EN_IN && pe_q
        |-> ##[1:12] (st_q == ST_SAVE && idx_q == NV_MOTOR_HOURS))
        else $error("motor hours not saved on pulse stop");
    maint_flt_a: assert property (
        maint_q != '0 && motor_hours >= maint_q |=> MAINT_FAULT_OUT)
        else $error("maintenance fault not raised");
    fan_rej_a: assert property (
        fan_wr_bad && !fan_hr && !ld_fan |=> $stable(fan_hours))
        else $error("nonzero fan hours write accepted");
    fan_off_a: assert property (
        fan_life_q == '0 |=> !FAN_ALARM_OUT)
        else $error("fan alarm with monitoring off");
    tick_gap_a: assert property (
        ms_tick |=> !ms_tick ##0 presc == '0)
        else $error("millisecond tick too frequent");
endmodule
`default_nettype wire

// ==== tb/test_runtime_hours_counters.sv ====
// self-checking bench of the runtime hours counters
`timescale 1ns/100ps
`default_nettype none
module test_runtime_hours_counters import rhc_pkg::*; ();
    // ============================================================
    // signals and design
    logic clk = 0, rstn = 0, pen = 0, fan = 0, pf = 0, nvc = 1;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, v, a, b;
    logic [1:0] rsp;
    wire logic awr, wrr, bv, arr, rv, irq, mf, fa;
    wire logic [1:0] rr, br;
    wire logic [31:0] rdd;
    wire logic [2:0] pins;
    int n_mismatch = 0, check_count = 0, cyc = 0, c0, ca;
    assign pins = {fa, irq, mf};
    rhc_top #(.CYC_MS(4), .MS_HOUR(3)) rhc_top_i (
        .CLK_IN(clk), .RSTN_IN(rstn), .PULSE_EN_IN(pen), .FAN_RUN_IN(fan),
        .PWR_FAIL_IN(pf), .NV_CLEAR_IN(nvc), .AWVALID_IN(awv),
        .AWREADY_OUT(awr), .AWADDR_IN(awa), .WVALID_IN(wv), .WREADY_OUT(wrr),
        .WDATA_IN(wd), .WSTRB_IN(4'hf), .BVALID_OUT(bv), .BREADY_IN(bry),
        .BRESP_OUT(br), .ARVALID_IN(arv), .ARREADY_OUT(arr), .ARADDR_IN(ara),
        .RVALID_OUT(rv), .RREADY_IN(rry), .RDATA_OUT(rdd), .RRESP_OUT(rr),
        .IRQ_OUT(irq), .MAINT_FAULT_OUT(mf), .FAN_ALARM_OUT(fa));
    initial forever #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // ============================================================
    // helpers
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            $display("BAD %0t got %h exp %h", $time, g, e);
            n_mismatch++;
        end
    endtask
    // outputs are sampled at the falling edge, where they have settled
    task pin(input int k, input logic e);
        @(negedge clk);
        chk({31'h0, pins[k]}, {31'h0, e});
        @(posedge clk);
    endtask
    task rst;
        rstn <= 0;
        repeat (5) @(posedge clk);
        rstn <= 1;
        nvc <= 0;
    endtask
    // ends one idle edge later so a following call never reassigns a strobe
    task wr(input logic [7:0] ad, input logic [31:0] d);
        logic ah, wh, bh;
        int t;
        bh = 0;
        awa <= ad;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bry <= 1;
        for (t = 0; t < 40 && !bh; t++) begin
            @(negedge clk);
            ah = awr;
            wh = wrr;
            bh = bv;
            rsp = br;
            @(posedge clk);
            if (ah) awv <= 0;
            if (wh) wv <= 0;
        end
        bry <= 0;
        chk({31'h0, bh}, 32'h1);
        @(posedge clk);
    endtask
    task rd(input logic [7:0] ad);
        logic ah, dh;
        int t;
        dh = 0;
        ara <= ad;
        arv <= 1;
        rry <= 1;
        for (t = 0; t < 40 && !dh; t++) begin
            @(negedge clk);
            ah = arr;
            dh = rv;
            v = rdd;
            rsp = rr;
            c0 = cyc;
            @(posedge clk);
            if (ah) arv <= 0;
        end
        rry <= 0;
        chk({31'h0, dh}, 32'h1);
        @(posedge clk);
    endtask
    // ============================================================
    // scenarios
    task t_regs;
        rd(OFS_MAINT_INTERVAL);
        chk(v, MAINT_RESET);
        rd(OFS_FAN_LIFE);
        chk(v, FAN_LIFE_RESET);
        rd(OFS_IRQ_ENABLE);
        chk(v, {28'h0, IRQ_EN_RESET});
        rd(8'h40);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(8'h40, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        rd(OFS_TOTAL_DAYS);
        chk(v, 32'h0);
    endtask
    task t_motor;
        pen <= 1;
        repeat (40) @(posedge clk);
        rd(OFS_MOTOR_HOURS);
        chk(v, 32'h0);
        wr(OFS_MAINT_INTERVAL, 32'h2);
        repeat (60) @(posedge clk);
        pin(0, 1);
        rd(OFS_STATUS);
        a = 32'h1 << STS_RUNNING | 32'h1 << STS_PULSE;
        chk(v, a | 32'h1 << STS_MAINT);
        wr(OFS_IRQ_ENABLE, 32'h1);
        pin(1, 1);
        wr(OFS_IRQ_CLEAR, 32'hf);
        pin(1, 0);
        wr(OFS_MAINT_INTERVAL, 32'h100);
        pin(0, 0);
        pen <= 0;
        repeat (10) @(posedge clk);
        rd(OFS_IRQ_STATUS);
        chk({31'h0, v[IRQ_SAVED]}, 32'h1);
        rd(OFS_MOTOR_HOURS);
        a = v;
        chk({31'h0, v >= 32'h2}, 32'h1);
        repeat (30) @(posedge clk);
        rd(OFS_MOTOR_HOURS);
        chk(v, a);
    endtask
    task t_fan;
        wr(OFS_FAN_HOURS, 32'h5);
        rd(OFS_FAN_HOURS);
        chk(v, 32'h0);
        rd(OFS_IRQ_STATUS);
        chk({31'h0, v[IRQ_FAN_REJ]}, 32'h1);
        fan <= 1;
        repeat (30) @(posedge clk);
        pin(2, 0);
        fan <= 0;
        wr(OFS_FAN_HOURS, 32'h0);
        rd(OFS_FAN_HOURS);
        chk(v, 32'h0);
        wr(OFS_FAN_LIFE, 32'h1f5);
        pin(2, 0);
        fan <= 1;
        repeat (20) @(posedge clk);
        fan <= 0;
        pin(2, 1);
        rd(OFS_FAN_HOURS);
        chk(v, 32'h1);
    endtask
    // tick phase is unknown, so one tick of slack is allowed
    task t_rel;
        rd(OFS_REL_MS);
        a = v;
        ca = c0;
        repeat (40) @(posedge clk);
        rd(OFS_REL_MS);
        ca = (c0 - ca) / 4;
        chk({31'h0, v - a >= ca && v - a <= ca + 1}, 32'h1);
    endtask
    task t_save;
        wr(OFS_IRQ_CLEAR, 32'hf);
        rd(OFS_MOTOR_HOURS);
        a = v;
        rd(OFS_TOTAL_MS);
        b = v;
        pf <= 1;
        repeat (10) @(posedge clk);
        pf <= 0;
        rd(OFS_IRQ_STATUS);
        chk({31'h0, v[IRQ_SAVED]}, 32'h1);
        rst();
        repeat (10) @(posedge clk);
        rd(OFS_MOTOR_HOURS);
        chk(v, a);
        rd(OFS_TOTAL_MS);
        chk({31'h0, v >= b}, 32'h1);
        rd(OFS_REL_MS);
        chk({31'h0, v < 32'h14}, 32'h1);
    endtask
    // ============================================================
    // run control
    task complete_run;
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        @(posedge clk);
        rst();
        repeat (10) @(posedge clk);
        t_regs();
        t_motor();
        t_fan();
        t_rel();
        t_save();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
